// ### verilog/udc_pins.sv
// Upconverter pin logic: parallel port, dual-role pin, side pins.
// Status, power-down and reset pins too.
// Assumes clk is the system clock and link_clk runs free.
// Software reaches the registers over APB.
`timescale 1ns/1ns

// Functional notes
// - Serial output drives only in input-only serial mode.
// - Resync aborts serial transfer; registers kept.
// - Select high: differential reference; low: single-ended.
// - Power-down halts logic; loop runs if selected.
// - Reset pin forces the default state.
// - Lock output follows loop lock three clk cycles later.
// - Overflow output low unless filters overflow.
// - Outside tone mode, dual pin is data clock out.
// - In tone mode, dual pin is update strobe in.
// - Profile change activates its word without strobe.
// - Gate low feeds zeros into I and Q paths.
// - First word after gate rise is I, then Q, alternating.
// - Words are 14-bit two's complement; interpolating mode uses only I.
// - Two profile pins choose one of four profiles.
// - Strobe rise loads selected tuning word.
module udc_pins (
    input  wire logic                         clk,
    input  wire logic                         reset,
    input  wire logic                         link_clk,
    // APB slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [udc_pkg::APB_AW-1:0]   paddr,
    input  wire logic [udc_pkg::APB_DW-1:0]   pwdata,
    output logic      [udc_pkg::APB_DW-1:0]   prdata,
    output logic                              pready,
    output logic                              pslverr,
    // Parallel port
    input  wire logic [udc_pkg::DATA_W-1:0]   parallel_data_bus,
    input  wire logic                         transmit_gate,
    input  wire logic                         data_clock_or_update_pin_i,
    output logic                              data_clock_or_update_pin_o,
    output logic                              data_clock_or_update_pin_oe_n,
    input  wire logic                         profile_select_msb,
    input  wire logic                         profile_select_lsb,
    // Control and status pins
    input  wire logic                         hw_reset,
    input  wire logic                         digital_power_down,
    input  wire logic                         diff_ref_select,
    input  wire logic                         serial_port_resync,
    input  wire logic                         pll_locked,
    input  wire logic                         filter_overflow_event,
    input  wire logic                         serial_read_active,
    input  wire logic                         serial_read_data,
    output logic                              serial_out_pin_o,
    output logic                              serial_out_pin_oe_n,
    output logic                              serial_port_abort,
    output logic                              ref_diff_mode,
    output logic                              digital_halt,
    output logic                              pll_enable,
    output logic                              loop_lock,
    output logic                              interp_filter_overflow,
    // Datapath towards the filters and synthesizer
    output logic      [udc_pkg::DATA_W-1:0]   i_sample,
    output logic      [udc_pkg::DATA_W-1:0]   q_sample,
    output logic                              sample_valid,
    output logic      [udc_pkg::TW_W-1:0]     active_tuning_word,
    output logic                              accumulator_load
);

    // System-domain pin synchronisers
    logic       hwrst_s1_reg, hwrst_s2_reg;
    logic       pd_s1_reg, pd_s2_reg;
    logic       diff_s1_reg, diff_s2_reg;
    logic       resync_s1_reg, resync_s2_reg;
    logic       lock_s1_reg, lock_s2_reg;
    logic       fud_s1_reg, fud_s2_reg, fud_prev_reg;
    logic [1:0] prof_s1_reg, prof_s2_reg, prof_prev_reg;
    logic       gate_s1_reg, gate_s2_reg;
    logic       rst_all;

    // Two flops per pin
    always_ff @(posedge clk) begin
        hwrst_s1_reg  <= hw_reset;
        hwrst_s2_reg  <= hwrst_s1_reg;
        pd_s1_reg     <= digital_power_down;
        pd_s2_reg     <= pd_s1_reg;
        diff_s1_reg   <= diff_ref_select;
        diff_s2_reg   <= diff_s1_reg;
        resync_s1_reg <= serial_port_resync;
        resync_s2_reg <= resync_s1_reg;
        lock_s1_reg   <= pll_locked;
        lock_s2_reg   <= lock_s1_reg;
        fud_s1_reg    <= data_clock_or_update_pin_i;
        fud_s2_reg    <= fud_s1_reg;
        prof_s1_reg   <= {profile_select_msb, profile_select_lsb};
        prof_s2_reg   <= prof_s1_reg;
        gate_s1_reg   <= transmit_gate;
        gate_s2_reg   <= gate_s1_reg;
    end

    assign rst_all = reset || hwrst_s2_reg;

    // Control register and derived mode
    logic [3:0]          ctrl_reg;
    udc_pkg::udc_mode_e  mode;
    logic                tone_mode;
    logic                sdio_in_only;
    logic                pll_keep;

    assign mode         = udc_pkg::udc_mode_e'(ctrl_reg[udc_pkg::CTRL_MODE_LSB +: 2]);
    assign tone_mode    = (mode == udc_pkg::UDC_MODE_TONE);
    assign sdio_in_only = ctrl_reg[udc_pkg::CTRL_SDIO_IN_BIT];
    assign pll_keep     = ctrl_reg[udc_pkg::CTRL_PLL_KEEP_BIT];

    // APB decode
    logic                       apb_first;
    logic                       apb_commit;
    logic                       hit_ctrl, hit_status, hit_active, hit_count, hit_tw;
    logic                       hit_any;
    logic [udc_pkg::PROF_W-1:0] tw_index;
    logic [udc_pkg::TW_W-1:0]   tw_rd_a, tw_rd_b;

    assign apb_first  = psel && penable && !pready;
    assign apb_commit = psel && penable && pready;
    assign hit_ctrl   = (paddr == udc_pkg::ADDR_CTRL);
    assign hit_status = (paddr == udc_pkg::ADDR_STATUS);
    assign hit_active = (paddr == udc_pkg::ADDR_ACTIVE_TW);
    assign hit_count  = (paddr == udc_pkg::ADDR_PAIR_COUNT);
    assign hit_tw     = ((paddr & ~udc_pkg::ADDR_TW_MASK) == udc_pkg::ADDR_TW_BASE);
    assign hit_any    = hit_ctrl || hit_status || hit_active || hit_count || hit_tw;
    assign tw_index   = paddr[udc_pkg::TW_IDX_LSB +: udc_pkg::PROF_W];

    // Profile tuning words
    udc_profile_mem #(
        .WIDTH (udc_pkg::TW_W),
        .DEPTH (udc_pkg::PROFILES),
        .AW    (udc_pkg::PROF_W)
    ) u_profiles (
        .clk       (clk),
        .wr_en     (apb_commit && pwrite && hit_tw),
        .wr_addr   (tw_index),
        .wr_data   (pwdata),
        .rd_a_addr (tw_index),
        .rd_a_data (tw_rd_a),
        .rd_b_addr (prof_s2_reg),
        .rd_b_data (tw_rd_b)
    );

    // Control register write
    always_ff @(posedge clk) begin
        if (rst_all) begin
            ctrl_reg <= udc_pkg::CTRL_RESET;
        end else if (apb_commit && pwrite && hit_ctrl) begin
            ctrl_reg <= pwdata[3:0];
        end
    end

    // Overflow sticky, set wins
    logic ovf_sticky_reg;
    always_ff @(posedge clk) begin
        if (rst_all) begin
            ovf_sticky_reg <= 1'b0;
        end else if (filter_overflow_event) begin
            ovf_sticky_reg <= 1'b1;
        end else if (apb_commit && pwrite && hit_status && pwdata[udc_pkg::ST_OVF_BIT]) begin
            ovf_sticky_reg <= 1'b0;
        end
    end

    // APB answer after one wait state
    logic [udc_pkg::APB_DW-1:0]  status_word;
    logic [udc_pkg::COUNT_W-1:0] pair_count_reg;
    always_comb begin
        status_word = '0;
        status_word[udc_pkg::ST_LOCK_BIT] = lock_s2_reg;
        status_word[udc_pkg::ST_OVF_BIT]  = ovf_sticky_reg;
        status_word[udc_pkg::ST_GATE_BIT] = gate_s2_reg;
        status_word[udc_pkg::ST_HALT_BIT] = pd_s2_reg;
        status_word[udc_pkg::ST_PROFILE_LSB +: udc_pkg::PROF_W] = prof_s2_reg;
        status_word[udc_pkg::ST_DIFF_BIT] = diff_s2_reg;
    end

    always_ff @(posedge clk) begin
        if (rst_all) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (apb_first) begin
            pready  <= 1'b1;
            pslverr <= !hit_any;
            if (pwrite || !hit_any) begin
                prdata <= '0;
            end else if (hit_ctrl) begin
                prdata <= {28'h0000000, ctrl_reg};
            end else if (hit_status) begin
                prdata <= status_word;
            end else if (hit_active) begin
                prdata <= active_tuning_word;
            end else if (hit_count) begin
                prdata <= pair_count_reg;
            end else begin
                prdata <= tw_rd_a;
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Tuning word activation
    logic load_pend_reg;
    logic fud_rise;
    logic prof_change;
    assign fud_rise    = fud_s2_reg && !fud_prev_reg;
    assign prof_change = (prof_s2_reg != prof_prev_reg);

    always_ff @(posedge clk) begin
        if (rst_all) begin
            fud_prev_reg       <= 1'b0;
            prof_prev_reg      <= '0;
            load_pend_reg      <= 1'b0;
            active_tuning_word <= '0;
            accumulator_load   <= 1'b0;
        end else begin
            fud_prev_reg  <= fud_s2_reg;
            prof_prev_reg <= prof_s2_reg;
            load_pend_reg <= !pd_s2_reg && ((tone_mode && fud_rise) || prof_change);
            accumulator_load <= load_pend_reg;
            if (load_pend_reg) begin
                active_tuning_word <= tw_rd_b;
            end
        end
    end

    // Side pins and status
    always_ff @(posedge clk) begin
        if (rst_all) begin
            serial_out_pin_o       <= 1'b0;
            serial_out_pin_oe_n    <= 1'b1;
            serial_port_abort      <= 1'b0;
            ref_diff_mode          <= 1'b0;
            digital_halt           <= 1'b0;
            pll_enable             <= 1'b1;
            loop_lock              <= 1'b0;
            interp_filter_overflow <= 1'b0;
        end else begin
            serial_out_pin_o    <= serial_read_data;
            serial_out_pin_oe_n <= !(sdio_in_only && serial_read_active && !resync_s2_reg);
            serial_port_abort   <= resync_s2_reg;
            ref_diff_mode       <= diff_s2_reg;
            digital_halt        <= pd_s2_reg;
            pll_enable          <= !pd_s2_reg || pll_keep;
            loop_lock           <= lock_s2_reg;
            interp_filter_overflow <= filter_overflow_event;
        end
    end

    // Link-domain synchronisers
    logic rst_l1_reg, rst_l2_reg;
    logic tone_l1_reg, tone_l2_reg;
    logic interp_l1_reg, interp_l2_reg;
    logic halt_l1_reg, halt_l2_reg;
    always_ff @(posedge link_clk) begin
        rst_l1_reg    <= rst_all;
        rst_l2_reg    <= rst_l1_reg;
        tone_l1_reg   <= tone_mode;
        tone_l2_reg   <= tone_l1_reg;
        interp_l1_reg <= (mode == udc_pkg::UDC_MODE_INTERP);
        interp_l2_reg <= interp_l1_reg;
        halt_l1_reg   <= pd_s2_reg;
        halt_l2_reg   <= halt_l1_reg;
    end

    // Port pins, two link flops
    logic [udc_pkg::DATA_W-1:0] word_l1_reg, word_l2_reg;
    logic                       txg_l1_reg, txg_l2_reg;
    always_ff @(posedge link_clk) begin
        word_l1_reg <= parallel_data_bus;
        word_l2_reg <= word_l1_reg;
        txg_l1_reg  <= transmit_gate;
        txg_l2_reg  <= txg_l1_reg;
    end

    // Word clock, parked in tone or halt
    logic word_clk_reg;
    logic word_accept;
    always_ff @(posedge link_clk) begin
        if (rst_l2_reg) begin
            word_clk_reg                  <= 1'b0;
            data_clock_or_update_pin_oe_n <= 1'b0;
        end else begin
            data_clock_or_update_pin_oe_n <= tone_l2_reg;
            word_clk_reg <= !tone_l2_reg && !halt_l2_reg && !word_clk_reg;
        end
    end
    assign data_clock_or_update_pin_o = word_clk_reg;
    assign word_accept = word_clk_reg && !tone_l2_reg && !halt_l2_reg;

    udc_iq_if iq_bus ();

    udc_iq_demux u_demux (
        .link_clk    (link_clk),
        .link_reset  (rst_l2_reg),
        .accept      (word_accept),
        .word_in     (word_l2_reg),
        .gate_in     (txg_l2_reg),
        .interp_mode (interp_l2_reg),
        .iq          (iq_bus.src)
    );

    // Pair handover by toggle
    logic pt_s1_reg, pt_s2_reg, pt_prev_reg;
    always_ff @(posedge clk) begin
        pt_s1_reg <= iq_bus.pair_toggle;
        pt_s2_reg <= pt_s1_reg;
    end

    always_ff @(posedge clk) begin
        if (rst_all) begin
            pt_prev_reg    <= 1'b0;
            sample_valid   <= 1'b0;
            i_sample       <= '0;
            q_sample       <= '0;
            pair_count_reg <= '0;
        end else begin
            pt_prev_reg  <= pt_s2_reg;
            sample_valid <= (pt_s2_reg != pt_prev_reg) && !pd_s2_reg;
            if ((pt_s2_reg != pt_prev_reg) && !pd_s2_reg) begin
                i_sample       <= iq_bus.i_word;
                q_sample       <= iq_bus.q_word;
                pair_count_reg <= pair_count_reg + 1'b1;
            end
        end
    end

endmodule : udc_pins

// ### verilog/udc_pkg.sv
// Upconverter pin block constants: widths, modes, offsets, fields.
// Assumes a 32-bit APB slave, byte addresses on 8-bit paddr.
package udc_pkg;

    // Datapath widths
    localparam int DATA_W      = 14;
    localparam int TW_W        = 32;
    localparam int PROFILES    = 4;
    localparam int PROF_W      = 2;
    localparam int APB_AW      = 8;
    localparam int APB_DW      = 32;
    localparam int COUNT_W     = 32;

    // Control register modes
    typedef enum logic [1:0] {
        UDC_MODE_QUAD   = 2'b00,
        UDC_MODE_TONE   = 2'b01,
        UDC_MODE_INTERP = 2'b10
    } udc_mode_e;

    // Register byte offsets
    localparam logic [APB_AW-1:0] ADDR_CTRL       = 8'h00;
    localparam logic [APB_AW-1:0] ADDR_STATUS     = 8'h04;
    localparam logic [APB_AW-1:0] ADDR_ACTIVE_TW  = 8'h08;
    localparam logic [APB_AW-1:0] ADDR_PAIR_COUNT = 8'h0c;
    localparam logic [APB_AW-1:0] ADDR_TW_BASE    = 8'h10;
    localparam logic [APB_AW-1:0] ADDR_TW_MASK    = 8'h0c;
    localparam int                TW_IDX_LSB      = 2;

    // Control register fields
    localparam int CTRL_MODE_LSB     = 0;
    localparam int CTRL_SDIO_IN_BIT  = 2;
    localparam int CTRL_PLL_KEEP_BIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // Status register fields
    localparam int ST_LOCK_BIT    = 0;
    localparam int ST_OVF_BIT     = 1;
    localparam int ST_GATE_BIT    = 2;
    localparam int ST_HALT_BIT    = 3;
    localparam int ST_PROFILE_LSB = 4;
    localparam int ST_DIFF_BIT    = 6;

endpackage : udc_pkg

// ### verilog/udc_iq_if.sv
// I/Q pair carrier out of the link domain.
// Assumes words are read only after pair_toggle moves.
`timescale 1ns/1ns
interface udc_iq_if;
    logic [udc_pkg::DATA_W-1:0] i_word;
    logic [udc_pkg::DATA_W-1:0] q_word;
    logic                       pair_toggle;

    modport src (output i_word, output q_word, output pair_toggle);
    modport dst (input i_word, input q_word, input pair_toggle);
endinterface : udc_iq_if

// ### verilog/udc_profile_mem.sv
// Profile store: one write, two registered read ports.
// Assumes one clock; read data one edge after address.
`timescale 1ns/1ns
module udc_profile_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4,
    parameter int AW    = 2
) (
    input  wire logic             clk,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [AW-1:0]    rd_a_addr,
    output logic      [WIDTH-1:0] rd_a_data,
    input  wire logic [AW-1:0]    rd_b_addr,
    output logic      [WIDTH-1:0] rd_b_data
);

    logic [WIDTH-1:0] mem [DEPTH];

    // Write port
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read ports
    always_ff @(posedge clk) begin
        rd_a_data <= mem[rd_a_addr];
        rd_b_data <= mem[rd_b_addr];
    end

endmodule : udc_profile_mem

// ### verilog/udc_iq_demux.sv
// Link-clock demultiplexer: gated words into I/Q pairs.
// Assumes inputs already synchronised to link_clk.
`timescale 1ns/1ns
module udc_iq_demux (
    input  wire logic                       link_clk,
    input  wire logic                       link_reset,
    input  wire logic                       accept,
    input  wire logic [udc_pkg::DATA_W-1:0] word_in,
    input  wire logic                       gate_in,
    input  wire logic                       interp_mode,
    udc_iq_if.src                           iq
);

    logic [udc_pkg::DATA_W-1:0] i_hold_reg;
    logic [udc_pkg::DATA_W-1:0] i_out_reg;
    logic [udc_pkg::DATA_W-1:0] q_out_reg;
    logic                       toggle_reg;
    logic                       expect_q_reg;
    logic                       gate_prev_reg;
    logic [udc_pkg::DATA_W-1:0] word_gated;
    logic                       first_word;

    assign word_gated = gate_in ? word_in : '0;
    assign first_word = gate_in && !gate_prev_reg;

    // Word steering
    always_ff @(posedge link_clk) begin
        if (link_reset) begin
            i_hold_reg    <= '0;
            i_out_reg     <= '0;
            q_out_reg     <= '0;
            toggle_reg    <= 1'b0;
            expect_q_reg  <= 1'b0;
            gate_prev_reg <= 1'b0;
        end else if (accept) begin
            gate_prev_reg <= gate_in;
            if (interp_mode) begin
                i_out_reg    <= word_gated;
                q_out_reg    <= '0;
                toggle_reg   <= !toggle_reg;
                expect_q_reg <= 1'b0;
            end else if (expect_q_reg && !first_word) begin
                i_out_reg    <= i_hold_reg;
                q_out_reg    <= word_gated;
                toggle_reg   <= !toggle_reg;
                expect_q_reg <= 1'b0;
            end else begin
                i_hold_reg   <= word_gated;
                expect_q_reg <= 1'b1;
            end
        end
    end

    assign iq.i_word      = i_out_reg;
    assign iq.q_word      = q_out_reg;
    assign iq.pair_toggle = toggle_reg;

endmodule : udc_iq_demux

// ### dv/udc_pins_sva.sv
// Checker for the upconverter pin block.
// Assumes binding into udc_pins; all checks on clk.
`timescale 1ns/1ns
module udc_pins_sva (
    input wire logic clk,
    input wire logic reset,
    input wire logic pready,
    input wire logic serial_read_active,
    input wire logic serial_out_pin_oe_n,
    input wire logic serial_port_abort,
    input wire logic diff_ref_select,
    input wire logic ref_diff_mode,
    input wire logic digital_power_down,
    input wire logic digital_halt,
    input wire logic hw_reset,
    input wire logic sample_valid,
    input wire logic accumulator_load,
    input wire logic pll_locked,
    input wire logic loop_lock,
    input wire logic filter_overflow_event,
    input wire logic interp_filter_overflow,
    input wire logic data_clock_or_update_pin_i,
    input wire logic data_clock_or_update_pin_o,
    input wire logic data_clock_or_update_pin_oe_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Update strobe rising and held while the pin is an input
    sequence strobe_rise;
        data_clock_or_update_pin_oe_n && !digital_halt && $rose(data_clock_or_update_pin_i)
            ##1 data_clock_or_update_pin_i [*2];
    endsequence
    // Strobe leads to one load pulse
    sequence one_load;
        ##[1:4] accumulator_load ##1 !accumulator_load;
    endsequence
    serial_drive_a: assert property (!serial_out_pin_oe_n |-> $past(serial_read_active))
        else $error("serial drive");
    resync_off_a: assert property (serial_port_abort |-> serial_out_pin_oe_n)
        else $error("resync drive");
    diff_ref_a: assert property (diff_ref_select [*5] |-> ref_diff_mode)
        else $error("diff ref");
    pd_halt_a: assert property (digital_power_down [*5] |-> digital_halt)
        else $error("no halt");
    pin_reset_a: assert property (hw_reset [*5] |-> !sample_valid && !accumulator_load && !pready)
        else $error("pin reset");
    lock_follow_a: assert property ($stable(pll_locked) [*3] |-> loop_lock == pll_locked)
        else $error("lock output");
    ovf_quiet_a: assert property (!filter_overflow_event |=> !interp_filter_overflow)
        else $error("overflow output");
    tone_pin_a: assert property (data_clock_or_update_pin_oe_n [*2] |-> !data_clock_or_update_pin_o)
        else $error("tone clock");
    strobe_load_a: assert property (strobe_rise |-> one_load)
        else $error("strobe load");
endmodule : udc_pins_sva

bind udc_pins udc_pins_sva u_sva (.*);

// ### dv/udc_src_model.sv
// Baseband source model: numbered words on the word clock.
// Assumes word clock and pin direction reach it directly.
`timescale 1ns/1ns
module udc_src_model (
    input  wire logic        link_clk,
    input  wire logic        pin_o,
    input  wire logic        oe_n,
    input  wire logic        gate_req,
    output logic      [13:0] data,
    output logic             gate
);
    logic [13:0] word_reg = 14'h0;
    logic [13:0] idle_reg = 14'h0;
    logic        gate_reg = 1'b0;
    int          k = 0;
    // signed words on clock rise, I first after gate
    always @(posedge pin_o) begin
        gate_reg <= gate_req;
        word_reg <= gate_req ? 14'h2a00 + 14'(k) : 14'h1555;
        k <= gate_req ? k + 1 : 0;
    end
    // Released port keeps changing
    always @(posedge link_clk) idle_reg <= ~data;
    assign data = oe_n ? idle_reg : word_reg;
    assign gate = gate_reg;
endmodule : udc_src_model

// ### dv/test_udc_pins.sv
// Testbench for the upconverter pin block.
// Assumes the source model paces words from the word clock.
`timescale 1ns/1ns
module test_udc_pins;
    logic        clk, reset, link_clk, psel, penable, pwrite, pready, pslverr, err, gate_req;
    logic        transmit_gate, data_clock_or_update_pin_i, data_clock_or_update_pin_o;
    logic        data_clock_or_update_pin_oe_n, profile_select_msb, profile_select_lsb;
    logic        hw_reset, digital_power_down, diff_ref_select, serial_port_resync;
    logic        pll_locked, filter_overflow_event, serial_read_active, serial_read_data;
    logic        serial_out_pin_o, serial_out_pin_oe_n, serial_port_abort, ref_diff_mode;
    logic        digital_halt, pll_enable, loop_lock, interp_filter_overflow;
    logic        sample_valid, accumulator_load;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, active_tuning_word;
    logic [13:0] parallel_data_bus, i_sample, q_sample;
    int          num_errors, n_compared;

    udc_pins uut (.*);
    udc_src_model src (.link_clk(link_clk), .pin_o(data_clock_or_update_pin_o),
        .oe_n(data_clock_or_update_pin_oe_n), .gate_req(gate_req),
        .data(parallel_data_bus), .gate(transmit_gate));

    // Clocks, unrelated in phase
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #24 link_clk = ~link_clk;
    end

    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic to(input logic hit);
        chk("timeout", hit, 1'b0);
        if (hit) print_verdict();
    endtask : to

    // APB transfer, held to the edge that samples pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk) penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        to(n >= 50);
    endtask : apb

    // Wait for a load or sample pulse
    task automatic wait_ev(input logic load, input logic nz);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while ((load ? accumulator_load : sample_valid && (!nz || i_sample !== 14'h0))
                   !== 1'b1 && n < 400);
        to(n >= 400);
    endtask : wait_ev

    initial begin
        {psel, penable, pwrite, gate_req, data_clock_or_update_pin_i, hw_reset} = '0;
        {profile_select_msb, profile_select_lsb, digital_power_down, diff_ref_select} = '0;
        {serial_port_resync, pll_locked, filter_overflow_event, serial_read_active} = '0;
        {serial_read_data, paddr, pwdata, num_errors, n_compared} = '0;
        reset = 1'b1;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        // Registers
        apb(1'b0, udc_pkg::ADDR_CTRL, 32'h0);
        chk("ctrl_reset", rd, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped_err", err, 1'b1);
        for (int p = 0; p < 4; p++) apb(1'b1, udc_pkg::ADDR_TW_BASE + 8'(4 * p), 32'h12340000 + p);
        $display("registers done");
        // Quadrature order and gating
        chk("oe_n_quad", data_clock_or_update_pin_oe_n, 1'b0);
        @(posedge clk) gate_req <= 1'b1;
        wait_ev(1'b0, 1'b1);
        chk("i_first", i_sample, 14'h2a00);
        chk("q_first", q_sample, 14'h2a01);
        wait_ev(1'b0, 1'b0);
        chk("i_second", i_sample, 14'h2a02);
        @(posedge clk) gate_req <= 1'b0;
        repeat (3) wait_ev(1'b0, 1'b0);
        chk("iq_gated", {i_sample, q_sample}, 32'h0);
        // Interpolating: every word to I
        apb(1'b1, udc_pkg::ADDR_CTRL, 32'(udc_pkg::UDC_MODE_INTERP));
        @(posedge clk) gate_req <= 1'b1;
        wait_ev(1'b0, 1'b1);
        chk("interp_0", {i_sample, q_sample}, {14'h2a00, 14'h0});
        wait_ev(1'b0, 1'b0);
        chk("interp_1", i_sample, 14'h2a01);
        @(posedge clk) gate_req <= 1'b0;
        $display("port done");
        // Tone: strobe, then profiles
        apb(1'b1, udc_pkg::ADDR_CTRL, 32'(udc_pkg::UDC_MODE_TONE));
        repeat (10) @(posedge clk);
        chk("oe_n_tone", data_clock_or_update_pin_oe_n, 1'b1);
        @(posedge clk) data_clock_or_update_pin_i <= 1'b1;
        wait_ev(1'b1, 1'b0);
        chk("strobe_tw", active_tuning_word, 32'h12340000);
        @(posedge clk) data_clock_or_update_pin_i <= 1'b0;
        for (int p = 1; p < 4; p++) begin
            @(posedge clk) {profile_select_msb, profile_select_lsb} <= 2'(p);
            wait_ev(1'b1, 1'b0);
            chk("profile_tw", active_tuning_word, 32'h12340000 + p);
        end
        $display("tuning done");
        // Serial output and resync
        apb(1'b1, udc_pkg::ADDR_CTRL, 32'h4);
        @(posedge clk) serial_read_active <= 1'b1;
        serial_read_data <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("serial_on", {serial_out_pin_oe_n, serial_out_pin_o}, 2'b01);
        @(posedge clk) serial_port_resync <= 1'b1;
        repeat (4) @(posedge clk);
        #1 chk("resync_off", {serial_port_abort, serial_out_pin_oe_n}, 2'b11);
        @(posedge clk) serial_port_resync <= 1'b0;
        serial_read_active <= 1'b0;
        apb(1'b0, udc_pkg::ADDR_TW_BASE + 8'h4, 32'h0);
        chk("tw_kept", rd, 32'h12340001);
        // Power-down and loop
        apb(1'b1, udc_pkg::ADDR_CTRL, 32'h8);
        @(posedge clk) digital_power_down <= 1'b1;
        repeat (5) @(posedge clk);
        #1 chk("halt_pll", {digital_halt, pll_enable}, 2'b11);
        apb(1'b1, udc_pkg::ADDR_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        #1 chk("pll_off", pll_enable, 1'b0);
        @(posedge clk) digital_power_down <= 1'b0;
        diff_ref_select <= 1'b1;
        pll_locked <= 1'b1;
        filter_overflow_event <= 1'b1;
        @(posedge clk) filter_overflow_event <= 1'b0;
        repeat (5) @(posedge clk);
        #1 chk("diff_lock", {ref_diff_mode, loop_lock}, 2'b11);
        apb(1'b0, udc_pkg::ADDR_STATUS, 32'h0);
        chk("status", rd[1:0], 2'b11);
        $display("pins done");
        // Pin reset
        @(posedge clk) diff_ref_select <= 1'b0;
        pll_locked <= 1'b0;
        apb(1'b1, udc_pkg::ADDR_CTRL, 32'h5);
        @(posedge clk) hw_reset <= 1'b1;
        repeat (6) @(posedge clk);
        hw_reset <= 1'b0;
        repeat (6) @(posedge clk);
        apb(1'b0, udc_pkg::ADDR_CTRL, 32'h0);
        chk("ctrl_pin_reset", rd, 32'h0);
        $display("reset done");
        print_verdict();
    end
endmodule : test_udc_pins
